// >>> logic/smpsbp_pkg.sv
// smpsbp_pkg: constants and carrier types of the burst and protection control
package smpsbp_pkg;

	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned BURST_BLANK_MS = 20;
	localparam int unsigned OVERLOAD_BLANK_MS = 40;
	localparam int unsigned LATCH_BLANK_US = 210;
	localparam int unsigned BROWNOUT_BLANK_US = 270;
	localparam int unsigned AC_RESET_RISE_US = 450;
	localparam int unsigned BURST_BLANK_CYC = BURST_BLANK_MS * (CLK_HZ / 1000);
	localparam int unsigned OVERLOAD_BLANK_CYC = OVERLOAD_BLANK_MS * (CLK_HZ / 1000);
	localparam int unsigned LATCH_BLANK_CYC = LATCH_BLANK_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BROWNOUT_BLANK_CYC = BROWNOUT_BLANK_US * (CLK_HZ / 1_000_000);
	localparam int unsigned AC_RESET_RISE_CYC = AC_RESET_RISE_US * (CLK_HZ / 1_000_000);

	localparam int CNT_W = 24;
	localparam int CYC_W = 8;
	localparam int AW = 4;
	localparam int DW = 32;

	localparam logic [AW-1:0] CTRL_OFFSET = 4'h0;
	localparam logic [AW-1:0] STATUS_OFFSET = 4'h4;
	localparam int CTRL_BURST_BIT = 0;
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_VAR_LSB = 4;
	localparam int STAT_CYC_LSB = 8;
	localparam int STAT_DRIVE_LSB = 16;
	localparam logic CTRL_BURST_RESET = 1'h1;
	localparam logic [CYC_W-1:0] FIRST_CYCLE = 8'h01;

	typedef enum logic [2:0] {
		mode_charge,
		mode_run,
		mode_normal,
		mode_burst_off,
		mode_burst_on,
		mode_latched
	} smpsbp_mode_t;

	typedef enum logic [1:0] {
		var_brownout,
		var_normal,
		var_odd_skip,
		var_non_switch
	} smpsbp_variant_t;

	typedef struct packed {
		logic fb_below_entry;
		logic fb_above_3v5;
		logic fb_below_3v2;
		logic fb_above_4v0;
		logic fb_above_4v5;
		logic vcc_above_8v;
		logic vcc_above_on;
		logic vcc_below_off;
		logic vcc_above_ovp;
		logic temp_above_trip;
		logic temp_below_recover;
		logic brl_below_0v4;
		logic brl_below_1v;
		logic brl_above_1v25;
	} smpsbp_cmp_t;

	typedef struct packed {
		logic bias_enable;
		logic switch_enable;
		logic burst_limit_select;
		logic startup_enable;
	} smpsbp_drive_t;

	typedef struct packed {
		smpsbp_cmp_t sync1;
		smpsbp_cmp_t sync2;
		smpsbp_mode_t mode;
		smpsbp_variant_t variant;
		logic [CYC_W-1:0] cycle;
		smpsbp_drive_t drive;
		logic burst_allow;
		logic [DW-1:0] rdata;
	} smpsbp_state_t;

	localparam smpsbp_state_t STATE_RESET = '{
		sync1: '0,
		sync2: '0,
		mode: mode_charge,
		variant: var_brownout,
		cycle: FIRST_CYCLE,
		drive: '0,
		burst_allow: CTRL_BURST_RESET,
		rdata: '0
	};

endpackage : smpsbp_pkg

// >>> logic/smpsbp_control.sv
// smpsbp_control: light-load burst, auto-restart, latch and brownout mode control
// What this block does
// R1: enter burst only after feedback stays below entry level for 20 ms.
// R2: in burst, feedback above 3.5 V re-enables bias and switching.
// R3: in burst, every pulse uses the reduced burst current limit.
// R4: in burst, feedback down to 3.2 V switches bias off, stops switching.
// R5: feedback above 4.0 V in burst restores full current limit at once.
// R6: odd-skip restart: no fault check, no pulses on odd cycles.
// R7: odd-skip restart: even cycles check and switch; resume only then.
// R8: non-switching restart: never switch; check and resume on even cycles.
// R9: overvoltage, overload, open loop go odd-skip; undervoltage goes normal restart.
// R10: external protection request leads to latched-off, not auto-restart.
// R11: supply above 25.5 V enters odd-skip auto-restart.
// R12: over-temperature enters non-switching restart; recovers 50 degrees below trip.
// R13: brownout/latch pin below 0.4 V for 210 us latches off.
// R14: latched-off stops the gate drive until a latch reset occurs.
// R15: supply below 10.5 V turns off, charges, restarts at 17 V.
// R16: feedback above 4.5 V for 40 ms enters odd-skip restart.
// R17: brownout pin below 1 V for 270 us enters brownout mode.
// R18: brownout pin above 1.25 V leaves brownout for normal operation.
// R19: brownout works above 8 V and is forced during first startup.
// R20: brownout mode never switches and rechecks the pin every cycle.
// R21: supply below 8 V clears the latched-off state.
// R22: slow 0.4 V to 1 V rise of 450 us clears the latch.
// R23: restart counter starts at one, counts supply cycles, LSB marks odd.
// R24: blanking counters share one time base, reset when condition drops.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// blanking counter: done once qual has held for LIMIT cycles

module smpsbp_blank_counter #(
	parameter logic [smpsbp_pkg::CNT_W-1:0] LIMIT = 24'h000001
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic qual,
	output logic done
);
	import smpsbp_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] count;
	} smpsbp_cnt_t;

	smpsbp_cnt_t s;
	smpsbp_cnt_t next_s;

	always_comb begin
		next_s = s;
		if (!qual) begin
			next_s.count = '0; // R24
		end else if (s.count != LIMIT) begin
			next_s.count = s.count + 1'b1; // R24
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = (s.count == LIMIT);

endmodule : smpsbp_blank_counter

////////////////////////////////////////////////////////////////////////////////
// top: mode control

module smpsbp_control #(
	parameter int unsigned BURST_BLANK = smpsbp_pkg::BURST_BLANK_CYC,
	parameter int unsigned OVERLOAD_BLANK = smpsbp_pkg::OVERLOAD_BLANK_CYC,
	parameter int unsigned LATCH_BLANK = smpsbp_pkg::LATCH_BLANK_CYC,
	parameter int unsigned BROWNOUT_BLANK = smpsbp_pkg::BROWNOUT_BLANK_CYC,
	parameter int unsigned AC_RESET_RISE = smpsbp_pkg::AC_RESET_RISE_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire smpsbp_pkg::smpsbp_cmp_t cmp_in,
	input wire logic [smpsbp_pkg::AW-1:0] reg_addr,
	input wire logic [smpsbp_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [smpsbp_pkg::DW-1:0] reg_rdata,
	output smpsbp_pkg::smpsbp_drive_t drive
);
	import smpsbp_pkg::*;

	smpsbp_state_t s;
	smpsbp_state_t next_s;
	smpsbp_cmp_t cmp;
	logic active;
	logic burst_done;
	logic ol_done;
	logic latch_done;
	logic bo_done;
	logic rise_done;
	logic no_fault;
	logic detect;
	logic fault_still;
	logic sw_ok;

	assign cmp = s.sync2;
	assign active = (s.mode == mode_normal) || (s.mode == mode_burst_off)
		|| (s.mode == mode_burst_on);

	////////////////////////////////////////////////////////////////////////////
	// blanking timers

	smpsbp_blank_counter #(.LIMIT(CNT_W'(BURST_BLANK))) u_burst_blank (
		.sys_clk(sys_clk),
		.reset(reset),
		.qual((s.mode == mode_normal) && cmp.fb_below_entry), // R1
		.done(burst_done)
	);

	smpsbp_blank_counter #(.LIMIT(CNT_W'(OVERLOAD_BLANK))) u_overload_blank (
		.sys_clk(sys_clk),
		.reset(reset),
		.qual(active && cmp.fb_above_4v5), // R16
		.done(ol_done)
	);

	smpsbp_blank_counter #(.LIMIT(CNT_W'(LATCH_BLANK))) u_latch_blank (
		.sys_clk(sys_clk),
		.reset(reset),
		.qual(active && cmp.brl_below_0v4), // R13
		.done(latch_done)
	);

	smpsbp_blank_counter #(.LIMIT(CNT_W'(BROWNOUT_BLANK))) u_brownout_blank (
		.sys_clk(sys_clk),
		.reset(reset),
		.qual(active && cmp.vcc_above_8v && cmp.brl_below_1v), // R17 R19
		.done(bo_done)
	);

	// slow rise from 0.4 V to 1 V while latched
	smpsbp_blank_counter #(.LIMIT(CNT_W'(AC_RESET_RISE))) u_rise_blank (
		.sys_clk(sys_clk),
		.reset(reset),
		.qual((s.mode == mode_latched) && !cmp.brl_below_0v4 && cmp.brl_below_1v), // R22
		.done(rise_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// fault summary and restart-cycle qualification

	assign no_fault = cmp.vcc_above_8v && !latch_done && !cmp.temp_above_trip
		&& !cmp.vcc_above_ovp && !ol_done && !bo_done && !cmp.vcc_below_off;

	always_comb begin
		detect = 1'b1;
		fault_still = 1'b0;
		sw_ok = 1'b0;
		case (s.variant)
			var_normal: begin
				sw_ok = 1'b1;
			end
			var_brownout: begin
				fault_still = !cmp.brl_above_1v25; // R18 R20
			end
			var_odd_skip: begin
				detect = !s.cycle[0]; // R6 R7
				fault_still = cmp.vcc_above_ovp || cmp.fb_above_4v5; // R7
				sw_ok = !s.cycle[0]; // R6 R7
			end
			var_non_switch: begin
				detect = !s.cycle[0]; // R8
				fault_still = !cmp.temp_below_recover; // R12
			end
			default: begin
				detect = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_s = s;
		next_s.sync1 = cmp_in;
		next_s.sync2 = s.sync1;

		if (reg_wr && (reg_addr == CTRL_OFFSET)) begin
			next_s.burst_allow = reg_wdata[CTRL_BURST_BIT];
		end
		next_s.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				CTRL_OFFSET: begin
					next_s.rdata = DW'(s.burst_allow) << CTRL_BURST_BIT;
				end
				STATUS_OFFSET: begin
					next_s.rdata = (DW'(s.mode) << STAT_MODE_LSB)
						| (DW'(s.variant) << STAT_VAR_LSB)
						| (DW'(s.cycle) << STAT_CYC_LSB)
						| (DW'(s.drive) << STAT_DRIVE_LSB);
				end
				default: begin
					next_s.rdata = '0;
				end
			endcase
		end

		if (!cmp.vcc_above_8v) begin
			next_s.mode = mode_charge; // R21
			next_s.variant = var_brownout; // R19
			next_s.cycle = FIRST_CYCLE;
		end else begin
			case (s.mode)
				mode_normal, mode_burst_off, mode_burst_on: begin
					if (latch_done) begin
						next_s.mode = mode_latched; // R10 R13
					end else if (cmp.temp_above_trip) begin
						next_s.mode = mode_run; // R12
						next_s.variant = var_non_switch;
						next_s.cycle = FIRST_CYCLE; // R23
					end else if (cmp.vcc_above_ovp || ol_done) begin
						next_s.mode = mode_run; // R9 R11 R16
						next_s.variant = var_odd_skip;
						next_s.cycle = FIRST_CYCLE; // R23
					end else if (bo_done) begin
						next_s.mode = mode_run; // R17 R20
						next_s.variant = var_brownout;
						next_s.cycle = FIRST_CYCLE; // R23
					end else if (cmp.vcc_below_off) begin
						next_s.mode = mode_charge; // R9 R15
						next_s.variant = var_normal;
						next_s.cycle = FIRST_CYCLE; // R23
					end else if (s.mode == mode_normal) begin
						if (burst_done && s.burst_allow) begin
							next_s.mode = mode_burst_off; // R1
						end
					end else if (cmp.fb_above_4v0) begin
						next_s.mode = mode_normal; // R5
					end else if ((s.mode == mode_burst_off) && cmp.fb_above_3v5) begin
						next_s.mode = mode_burst_on; // R2
					end else if ((s.mode == mode_burst_on) && cmp.fb_below_3v2) begin
						next_s.mode = mode_burst_off; // R4
					end
				end
				mode_charge: begin
					if (cmp.vcc_above_on) begin
						if (detect && !fault_still) begin
							next_s.mode = mode_normal; // R7 R8 R15 R18
						end else begin
							next_s.mode = mode_run;
						end
					end
				end
				mode_run: begin
					if (cmp.vcc_below_off) begin
						next_s.mode = mode_charge; // R15
						next_s.cycle = s.cycle + 1'b1; // R23
					end
				end
				mode_latched: begin
					if (rise_done && !cmp.brl_below_1v) begin
						next_s.mode = mode_charge; // R22
						next_s.variant = var_brownout;
						next_s.cycle = FIRST_CYCLE;
					end
				end
				default: begin
					next_s.mode = mode_charge;
				end
			endcase
		end

		// pin drive follows the mode being entered
		next_s.drive.bias_enable = (next_s.mode == mode_normal)
			|| (next_s.mode == mode_burst_on) || (next_s.mode == mode_run); // R2 R4 R14
		next_s.drive.switch_enable = (next_s.mode == mode_normal)
			|| (next_s.mode == mode_burst_on); // R2 R4 R14
		if ((next_s.mode == mode_run) && (next_s.variant == var_normal)) begin
			next_s.drive.switch_enable = 1'b1; // R15
		end
		if ((next_s.mode == mode_run) && (next_s.variant == var_odd_skip)) begin
			next_s.drive.switch_enable = !next_s.cycle[0]; // R6 R7
		end
		next_s.drive.burst_limit_select = (next_s.mode == mode_burst_off)
			|| (next_s.mode == mode_burst_on); // R3
		next_s.drive.startup_enable = (next_s.mode == mode_charge); // R15
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign drive = s.drive;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	sequence seq_burst;
		(s.mode == mode_burst_off) || (s.mode == mode_burst_on);
	endsequence

	sequence seq_enter_ar;
		(s.mode == mode_normal) ##1 (s.mode == mode_run);
	endsequence

	a_burst_limit: assert property ( // R3
		seq_burst |-> drive.burst_limit_select && !drive.startup_enable
	) else $error("burst mode without reduced current limit");

	a_burst_exit: assert property ( // R5
		((s.mode == mode_burst_off) || (s.mode == mode_burst_on)) && no_fault
		&& cmp.fb_above_4v0 |=> (s.mode == mode_normal) && !drive.burst_limit_select
	) else $error("burst not left on high feedback");

	a_burst_wake: assert property ( // R2
		(s.mode == mode_burst_off) && no_fault && cmp.fb_above_3v5 && !cmp.fb_above_4v0
		|=> (s.mode == mode_burst_on) && drive.bias_enable && drive.switch_enable
	) else $error("burst did not wake above upper level");

	a_burst_sleep: assert property ( // R4
		(s.mode == mode_burst_on) && no_fault && cmp.fb_below_3v2 && !cmp.fb_above_4v0
		|=> (s.mode == mode_burst_off) && !drive.bias_enable && !drive.switch_enable
	) else $error("burst did not sleep at lower level");

	a_odd_silent: assert property ( // R6
		(s.mode == mode_run) && (s.variant == var_odd_skip) && s.cycle[0]
		|-> !drive.switch_enable
	) else $error("switching in an odd skipped cycle");

	a_odd_no_return: assert property ( // R7
		(s.mode == mode_charge) && cmp.vcc_above_8v && cmp.vcc_above_on
		&& (s.variant == var_odd_skip) && s.cycle[0] |=> (s.mode == mode_run)
	) else $error("odd cycle returned to normal operation");

	a_nonsw_silent: assert property ( // R8
		(s.mode == mode_run) && (s.variant == var_non_switch) |-> !drive.switch_enable
	) else $error("switching in non-switching restart");

	a_latch_entry: assert property ( // R13
		active && latch_done && cmp.vcc_above_8v |=> (s.mode == mode_latched)
	) else $error("latch blanking expired without latch");

	a_latch_hold: assert property ( // R14
		(s.mode == mode_latched) && cmp.vcc_above_8v && !rise_done
		|=> (s.mode == mode_latched) && !drive.switch_enable && !drive.bias_enable
	) else $error("latched state left or gate active");

	a_vcc_reset: assert property ( // R21
		!cmp.vcc_above_8v |=> (s.mode == mode_charge) && (s.variant == var_brownout)
	) else $error("low supply did not reset to startup");

	a_cycle_start: assert property ( // R23
		seq_enter_ar |-> (s.cycle == FIRST_CYCLE)
	) else $error("restart counter not started at one");

	a_uv_restart: assert property ( // R15
		(s.mode == mode_run) && cmp.vcc_above_8v && cmp.vcc_below_off
		|=> (s.mode == mode_charge) && drive.startup_enable
		&& (s.cycle == $past(s.cycle) + 8'h01)
	) else $error("undervoltage did not start a new cycle");

	a_brownout_entry: assert property ( // R17
		active && bo_done && !latch_done && !cmp.temp_above_trip && !cmp.vcc_above_ovp
		&& !ol_done && cmp.vcc_above_8v |=> (s.mode == mode_run)
		&& (s.variant == var_brownout) && !drive.switch_enable
	) else $error("brownout blanking expired without brownout");

endmodule : smpsbp_control

// >>> verif/smpsbp_stage_model.sv
// smpsbp_stage_model: comparator view of the power stage, feedback and line sensing
`timescale 1ns/100ps

module smpsbp_stage_model #(
	parameter int ENTRY_MV = 1610
) (
	input int vcc_mv,
	input int fb_mv,
	input int brl_mv,
	input int temp_c,
	output smpsbp_pkg::smpsbp_cmp_t cmp
);
	import smpsbp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// levels in mV and degrees, each turned into one comparator result
	always_comb begin
		cmp.fb_below_entry = fb_mv < ENTRY_MV;
		cmp.fb_above_3v5 = fb_mv > 3500;
		cmp.fb_below_3v2 = fb_mv <= 3200;
		cmp.fb_above_4v0 = fb_mv > 4000;
		cmp.fb_above_4v5 = fb_mv > 4500;
		cmp.vcc_above_8v = vcc_mv > 8000;
		cmp.vcc_above_on = vcc_mv >= 17000;
		cmp.vcc_below_off = vcc_mv < 10500;
		cmp.vcc_above_ovp = vcc_mv > 25500;
		cmp.temp_above_trip = temp_c > 130;
		cmp.temp_below_recover = temp_c < 80;
		cmp.brl_below_0v4 = brl_mv < 400;
		cmp.brl_below_1v = brl_mv < 1000;
		cmp.brl_above_1v25 = brl_mv > 1250;
	end

endmodule : smpsbp_stage_model

// >>> verif/smps_burst_protection_control_test.sv
// smps_burst_protection_control_test: scenario bench of the burst and protection control
`timescale 1ns/100ps

module smps_burst_protection_control_test;
	import smpsbp_pkg::*;

	localparam int BB = 20;
	localparam int OB = 30;
	localparam int LB = 10;
	localparam int RB = 12;
	localparam int AB = 16;
	localparam logic [31:0] M_ALL = 32'h000f_ff37;
	localparam logic [31:0] M_N = 32'h000f_0007;
	localparam logic [31:0] M_SW = 32'h0004_ff37;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	smpsbp_cmp_t cmp_in;
	logic [AW-1:0] reg_addr = '0;
	logic [DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DW-1:0] reg_rdata;
	smpsbp_drive_t drive;
	int vcc = 9000;
	int fb = 2500;
	int brownout_latch_pin = 2000;
	int temp = 25;
	int failures = 0;
	int n_compared = 0;

	always #4 sys_clk = ~sys_clk;

	smpsbp_control #(.BURST_BLANK(BB), .OVERLOAD_BLANK(OB), .LATCH_BLANK(LB),
		.BROWNOUT_BLANK(RB), .AC_RESET_RISE(AB)) dut (.sys_clk(sys_clk), .reset(reset),
		.cmp_in(cmp_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive(drive));

	smpsbp_stage_model model (.vcc_mv(vcc), .fb_mv(fb), .brl_mv(brownout_latch_pin), .temp_c(temp),
		.cmp(cmp_in));

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : w

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	function automatic logic [31:0] sv(input smpsbp_mode_t m, input smpsbp_variant_t v,
		input logic [7:0] c, input logic [3:0] dr);
		return {12'h000, dr, c, 2'b00, v, 1'b0, m};
	endfunction : sv

	// status fields and the drive pins, both under one mask
	task automatic st(input logic [31:0] exp, input logic [31:0] msk);
		logic [31:0] d;
		rd(STATUS_OFFSET, d);
		chk(d & msk, exp & msk);
		chk({28'h0, drive & msk[19:16]}, {28'h0, exp[19:16] & msk[19:16]});
	endtask : st

	// one supply off/on cycle, then the mode that the new cycle settles in
	task automatic restart(input logic [7:0] c, input smpsbp_mode_t m,
		input smpsbp_variant_t v, input logic [3:0] dr);
		@(posedge sys_clk) vcc <= 10000;
		w(6);
		st(sv(mode_charge, v, c, 4'h1), M_ALL);
		@(posedge sys_clk) vcc <= 18000;
		w(6);
		st(sv(m, v, c, dr), (m == mode_normal) ? M_N : M_SW);
	endtask : restart

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_start();
		st(sv(mode_charge, var_brownout, 8'h01, 4'h1), M_ALL);
		@(posedge sys_clk) vcc <= 18000;
		w(6);
		st(sv(mode_normal, var_brownout, 8'h00, 4'hc), M_N);
		$display("test start done");
	endtask : t_start

	task automatic t_regs();
		logic [31:0] d;
		rd(CTRL_OFFSET, d);
		chk(d, 32'h0000_0001);
		wr(CTRL_OFFSET, 32'h0000_0000);
		wr(STATUS_OFFSET, 32'hffff_ffff);
		rd(CTRL_OFFSET, d);
		chk(d, 32'h0000_0000);
		rd(4'h8, d);
		chk(d, 32'h0000_0000);
		@(posedge sys_clk) fb <= 1000;
		w(BB + 6);
		st(sv(mode_normal, var_normal, 8'h00, 4'hc), M_N);
		@(posedge sys_clk) fb <= 2500;
		// let the expired burst blanking clear before entry is allowed again
		w(6);
		wr(CTRL_OFFSET, 32'h0000_0001);
		$display("test regs done");
	endtask : t_regs

	task automatic t_burst();
		@(posedge sys_clk) fb <= 1000;
		w(BB - 3);
		@(posedge sys_clk) fb <= 2500;
		st(sv(mode_normal, var_normal, 8'h00, 4'hc), M_N);
		@(posedge sys_clk) fb <= 1000;
		w(BB + 6);
		st(sv(mode_burst_off, var_normal, 8'h00, 4'h2), M_N);
		@(posedge sys_clk) fb <= 3600;
		w(6);
		st(sv(mode_burst_on, var_normal, 8'h00, 4'he), M_N);
		@(posedge sys_clk) fb <= 3100;
		w(6);
		st(sv(mode_burst_off, var_normal, 8'h00, 4'h2), M_N);
		@(posedge sys_clk) fb <= 4100;
		w(6);
		st(sv(mode_normal, var_normal, 8'h00, 4'hc), M_N);
		@(posedge sys_clk) fb <= 2500;
		$display("test burst done");
	endtask : t_burst

	task automatic t_overload();
		@(posedge sys_clk) fb <= 4600;
		w(OB - 3);
		@(posedge sys_clk) fb <= 2500;
		st(sv(mode_normal, var_normal, 8'h00, 4'hc), M_N);
		@(posedge sys_clk) fb <= 4600;
		w(OB + 6);
		st(sv(mode_run, var_odd_skip, 8'h01, 4'h0), M_SW);
		restart(8'h02, mode_run, var_odd_skip, 4'h4);
		restart(8'h03, mode_run, var_odd_skip, 4'h0);
		@(posedge sys_clk) fb <= 2500;
		restart(8'h04, mode_normal, var_odd_skip, 4'hc);
		$display("test overload done");
	endtask : t_overload

	task automatic t_ovp_otp_uv();
		@(posedge sys_clk) vcc <= 26000;
		w(6);
		st(sv(mode_run, var_odd_skip, 8'h01, 4'h0), M_SW);
		restart(8'h02, mode_normal, var_odd_skip, 4'hc);
		@(posedge sys_clk) temp <= 140;
		w(6);
		st(sv(mode_run, var_non_switch, 8'h01, 4'h0), M_SW);
		@(posedge sys_clk) temp <= 100;
		restart(8'h02, mode_run, var_non_switch, 4'h0);
		@(posedge sys_clk) temp <= 25;
		restart(8'h03, mode_run, var_non_switch, 4'h0);
		restart(8'h04, mode_normal, var_non_switch, 4'hc);
		restart(8'h01, mode_normal, var_normal, 4'hc);
		$display("test ovp otp uv done");
	endtask : t_ovp_otp_uv

	task automatic t_brownout();
		@(posedge sys_clk) brownout_latch_pin <= 900;
		w(RB + 6);
		st(sv(mode_run, var_brownout, 8'h01, 4'h0), M_SW);
		restart(8'h02, mode_run, var_brownout, 4'h0);
		@(posedge sys_clk) brownout_latch_pin <= 2000;
		restart(8'h03, mode_normal, var_brownout, 4'hc);
		$display("test brownout done");
	endtask : t_brownout

	task automatic t_latch();
		@(posedge sys_clk) brownout_latch_pin <= 300;
		w(LB - 3);
		@(posedge sys_clk) brownout_latch_pin <= 2000;
		st(sv(mode_normal, var_normal, 8'h00, 4'hc), M_N);
		@(posedge sys_clk) brownout_latch_pin <= 300;
		w(LB + 6);
		st(sv(mode_latched, var_normal, 8'h00, 4'h0), M_N);
		@(posedge sys_clk) brownout_latch_pin <= 700;
		w(AB - 6);
		@(posedge sys_clk) brownout_latch_pin <= 2000;
		w(6);
		st(sv(mode_latched, var_normal, 8'h00, 4'h0), M_N);
		@(posedge sys_clk) brownout_latch_pin <= 300;
		w(6);
		@(posedge sys_clk) brownout_latch_pin <= 700;
		w(AB + 6);
		@(posedge sys_clk) brownout_latch_pin <= 2000;
		vcc <= 9000;
		w(6);
		st(sv(mode_charge, var_brownout, 8'h01, 4'h1), M_ALL);
		@(posedge sys_clk) vcc <= 18000;
		w(6);
		st(sv(mode_normal, var_normal, 8'h00, 4'hc), M_N);
		@(posedge sys_clk) brownout_latch_pin <= 300;
		w(LB + 6);
		@(posedge sys_clk) brownout_latch_pin <= 2000;
		vcc <= 7000;
		w(6);
		st(sv(mode_charge, var_brownout, 8'h01, 4'h1), M_ALL);
		@(posedge sys_clk) vcc <= 9000;
		w(6);
		@(posedge sys_clk) vcc <= 18000;
		w(6);
		st(sv(mode_normal, var_normal, 8'h00, 4'hc), M_N);
		$display("test latch done");
	endtask : t_latch

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		w(2);
		t_start();
		t_regs();
		t_burst();
		t_overload();
		t_ovp_otp_uv();
		t_brownout();
		t_latch();
		complete_run();
	end

	// whole run is a few hundred cycles
	initial begin
		#200000;
		failures++;
		$display("watchdog expired");
		complete_run();
	end

endmodule : smps_burst_protection_control_test
